/* core/mpc_pkg.sv */
// Purpose: constants shared by the monitor pin control logic
// Assumes: 100 MHz core clock, AXI4-Lite register access
// Notes: byte addresses are aligned words
// Overview of operation
// RULE1: watchdog output asserts after 2.5 s with no serial clock activity
// RULE2: asserted watchdog pulls pin low and resets the configuration register
// RULE3: watchdog pin is open-drain pull-down only, never driven high
// RULE4: outside monitor mode, a 0 config bit pulls its general pin low
// RULE5: outside monitor mode, a 1 config bit releases its general pin
// RULE6: reading general pin config bits returns the real pin levels
// RULE7: monitor mode is active while the monitor-mode input is low
// RULE8: in monitor mode both general pins and watchdog pin are count inputs
// RULE9: four address straps form the serial address, high reads as 1
// RULE10: top-of-stack strap changes serial data out during toggle polling
// RULE11: serial data out is pull-down only; host supplies the pull-up
// RULE12: host selects the device by driving chip select low
// RULE13: discharge switches follow only host writes and watchdog reset
// RULE14: each device acts only on traffic carrying its own address
// RULE15: temperature inputs are stored in the temperature result register
// RULE16: actual watchdog timeout lies between 1 and 2.5 seconds
// RULE17: any serial clock edge restarts watchdog and releases its output
package mpc_pkg;
   // clock and timing
   localparam int unsigned CLK_MHZ = 100;
   // RULE16: timeout inside range
   localparam int unsigned WDT_TIMEOUT_MS = 2500;
   localparam int unsigned WDT_CYCLES = WDT_TIMEOUT_MS * 1000 * CLK_MHZ;

   // register byte addresses
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_PINS = 8'h04;
   localparam logic [7:0] ADDR_TEMP = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

   // configuration fields
   localparam int CFG_GENERAL_IO_ONE_BIT = 0;
   localparam int CFG_GENERAL_IO_TWO_BIT = 1;
   localparam int CFG_DSC_LSB = 2;
   localparam int NUM_CELLS = 12;
   localparam int CFG_W = CFG_DSC_LSB + NUM_CELLS;
   localparam logic [CFG_W-1:0] CFG_RESET = 14'h0003;

   // pin status fields
   localparam int PINS_ADDR_LSB = 0;
   localparam int PINS_TOS_BIT = 4;
   localparam int PINS_MON_BIT = 5;
   localparam int PINS_CNT_LSB = 6;
   localparam int PINS_WDT_BIT = 9;

   // temperature fields
   localparam int TEMP_W = 12;
   localparam int TEMP_TWO_LSB = 16;

   // interrupt bits
   localparam int IRQ_W = 3;
   localparam int IRQ_WDT_FIRE = 0;
   localparam int IRQ_TEMP_DONE = 1;
   localparam int IRQ_WDT_CLEAR = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0]
   {
      WR_IDLE = 1'b0,
      WR_RESP = 1'b1
   } mpc_wr_e;
endpackage : mpc_pkg

/* core/mpc_wdog.sv */
// Purpose: serial clock watchdog timer
// Assumes: serial clock input already synchronous to core_clk
// Notes: expired stays high until the next serial clock edge
`timescale 1ns/1ps
`default_nettype none
module mpc_wdog
#(
   parameter int unsigned CYCLES = mpc_pkg::WDT_CYCLES,
   parameter int CNT_W = $clog2(CYCLES + 1)
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic serial_clock_in,
   output logic sck_edge,
   output logic expired
);
   logic sck_q;
   logic [CNT_W-1:0] count;
   logic at_limit;

   // edge detect and limit compare
   assign sck_edge = serial_clock_in ^ sck_q;
   assign at_limit = (count == CNT_W'(CYCLES - 1));

   // sample serial clock
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         sck_q <= 1'b0;
      else
         sck_q <= serial_clock_in;
   end

   // RULE17: restart on edge
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         count <= '0;
      else if (sck_edge)
         count <= '0;
      else if (!at_limit)
         count <= count + CNT_W'(1);
   end

   // RULE1: timeout raises output
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         expired <= 1'b0;
      else if (sck_edge)
         expired <= 1'b0;
      else if (at_limit)
         expired <= 1'b1;
   end

   // checks on the core clock, off during reset
   default clocking cb_wdog @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   AST_WDT_FIRE: assert property (at_limit && !sck_edge |=> expired) // RULE1
      else $error("watchdog did not fire at limit");
   AST_WDT_EARLY: assert property (sck_edge |=> // RULE16
      !expired [*2] or (!expired ##1 sck_edge))
      else $error("watchdog fired right after activity");
   AST_WDT_RELEASE: assert property (expired && sck_edge |=> // RULE17
      !expired && count == '0)
      else $error("watchdog not released by clock edge");
endmodule : mpc_wdog
`default_nettype wire

/* core/mpc_pin_ctrl.sv */
// Purpose: control pins, watchdog, straps and registers of the cell monitor
// Assumes: all pin inputs synchronous to core_clk
// Notes: watchdog and general pins are split into input, output and enable; serial data out into output and enable
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mpc_pin_ctrl
#(
   parameter int unsigned WDT_CYCLES = mpc_pkg::WDT_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq,
   // device pins
   input wire logic serial_clock_in,
   input wire logic chip_select_in_n,
   input wire logic watchdog_fault_out_n_i,
   output logic watchdog_fault_out_n_o,
   output logic watchdog_fault_out_n_oe,
   input wire logic general_io_one_i,
   output logic general_io_one_o,
   output logic general_io_one_oe,
   input wire logic general_io_two_i,
   output logic general_io_two_o,
   output logic general_io_two_oe,
   input wire logic monitor_mode_in_n,
   input wire logic addr_strap_bit0,
   input wire logic addr_strap_bit1,
   input wire logic addr_strap_bit2,
   input wire logic addr_strap_bit3,
   input wire logic stack_top_strap,
   output logic serial_data_out_o,
   output logic serial_data_out_oe,
   // serial engine side
   input wire logic sdo_tx_bit,
   input wire logic poll_mode,
   input wire logic poll_toggle,
   input wire logic [3:0] rx_addr,
   output logic addr_match,
   output logic [3:0] dev_address,
   // measurement side
   input wire logic [11:0] temp_sense_in_one,
   input wire logic [11:0] temp_sense_in_two,
   input wire logic temp_conv_done,
   output logic [11:0] discharge_en,
   output logic [2:0] cell_count_sel,
   output logic monitor_mode
);
   localparam int CW = mpc_pkg::CFG_W;
   localparam int IW = mpc_pkg::IRQ_W;
   localparam int TW = mpc_pkg::TEMP_W;

   // byte-lane merge for writable words
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = nw[8*i +: 8];
      return res;
   endfunction : merge

   // address is one of the five words
   function automatic logic mapped(input logic [7:0] a);
      return a == mpc_pkg::ADDR_CFG || a == mpc_pkg::ADDR_PINS ||
         a == mpc_pkg::ADDR_TEMP || a == mpc_pkg::ADDR_IRQ_STAT ||
         a == mpc_pkg::ADDR_IRQ_MASK;
   endfunction : mapped

   logic wdt_expired, sck_edge, wdt_q;
   logic [CW-1:0] cfg;
   logic [IW-1:0] irq_stat, irq_mask, irq_set, irq_clr, next_irq_stat;
   logic [TW-1:0] temp_one, temp_two;
   logic aw_held, w_held, do_write, wr_cfg, wr_stat, wr_mask;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q, cfg_merged, mask_merged;
   logic [3:0] wstrb_q;
   mpc_pkg::mpc_wr_e wr_state;
   logic [31:0] rd_word, cfg_view, pins_view, temp_view;

   //------------------------------------------------------------
   // watchdog
   //------------------------------------------------------------
   mpc_wdog #(.CYCLES(WDT_CYCLES)) u_wdog
   (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .serial_clock_in(serial_clock_in),
      .sck_edge(sck_edge),
      .expired(wdt_expired)
   );

   //------------------------------------------------------------
   // pin drivers
   //------------------------------------------------------------
   // RULE7: low input selects monitor mode
   assign monitor_mode = !monitor_mode_in_n;
   // RULE3: watchdog pin only pulls low
   assign watchdog_fault_out_n_o = 1'b0;
   // RULE2: pulled low while expired, RULE8 input in monitor mode
   assign watchdog_fault_out_n_oe = wdt_expired && !monitor_mode;
   // RULE4: zero bit pulls pin low
   assign general_io_one_o = 1'b0;
   assign general_io_two_o = 1'b0;
   // RULE5: one bit or monitor mode releases pin
   assign general_io_one_oe = !monitor_mode && !cfg[mpc_pkg::CFG_GENERAL_IO_ONE_BIT];
   assign general_io_two_oe = !monitor_mode && !cfg[mpc_pkg::CFG_GENERAL_IO_TWO_BIT];
   // RULE11: serial data pull-down only
   assign serial_data_out_o = 1'b0;
   // RULE10: top of stack shows toggle, others release during polling
   assign serial_data_out_oe = !chip_select_in_n && (poll_mode ?
      (stack_top_strap && !poll_toggle) : !sdo_tx_bit);
   // RULE13: switches straight from host-written bits
   assign discharge_en = cfg[mpc_pkg::CFG_DSC_LSB +: mpc_pkg::NUM_CELLS];
   // RULE14: own address check for the serial engine
   assign addr_match = (rx_addr == dev_address);

   // RULE9: address and count pins captured
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dev_address <= 4'h0;
         cell_count_sel <= 3'h0;
         wdt_q <= 1'b0;
      end
      else
      begin
         dev_address <= {addr_strap_bit3, addr_strap_bit2,
                         addr_strap_bit1, addr_strap_bit0};
         if (monitor_mode)
            cell_count_sel <= {watchdog_fault_out_n_i, general_io_two_i,
                               general_io_one_i};
         wdt_q <= wdt_expired;
      end
   end

   //------------------------------------------------------------
   // write channel
   //------------------------------------------------------------
   assign s_axi_awready = !aw_held && wr_state == mpc_pkg::WR_IDLE;
   assign s_axi_wready = !w_held && wr_state == mpc_pkg::WR_IDLE;
   assign s_axi_bvalid = (wr_state == mpc_pkg::WR_RESP);
   assign do_write = aw_held && w_held && wr_state == mpc_pkg::WR_IDLE;
   assign wr_cfg = do_write && awaddr_q == mpc_pkg::ADDR_CFG;
   assign wr_stat = do_write && awaddr_q == mpc_pkg::ADDR_IRQ_STAT;
   assign wr_mask = do_write && awaddr_q == mpc_pkg::ADDR_IRQ_MASK;
   assign cfg_merged = merge(32'(cfg), wdata_q, wstrb_q);
   assign mask_merged = merge(32'(irq_mask), wdata_q, wstrb_q);

   // hold address and data until both are in
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   // response state
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_state <= mpc_pkg::WR_IDLE;
         s_axi_bresp <= mpc_pkg::RESP_OKAY;
      end
      else
      begin
         case (wr_state)
            mpc_pkg::WR_IDLE:
               if (do_write)
               begin
                  wr_state <= mpc_pkg::WR_RESP;
                  s_axi_bresp <= mapped(awaddr_q) ? mpc_pkg::RESP_OKAY :
                     mpc_pkg::RESP_SLVERR;
               end
            mpc_pkg::WR_RESP:
               if (s_axi_bready)
                  wr_state <= mpc_pkg::WR_IDLE;
            default:
               wr_state <= mpc_pkg::WR_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   // RULE2: watchdog forces default contents
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         cfg <= mpc_pkg::CFG_RESET;
      else if (wdt_expired)
         cfg <= mpc_pkg::CFG_RESET;
      else if (wr_cfg)
         cfg <= cfg_merged[CW-1:0];
   end

   // RULE15: temperature results stored
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         temp_one <= '0;
         temp_two <= '0;
      end
      else if (temp_conv_done)
      begin
         temp_one <= temp_sense_in_one;
         temp_two <= temp_sense_in_two;
      end
   end

   // sticky events, set wins over clear
   assign irq_set = {wdt_q && !wdt_expired, temp_conv_done,
                     wdt_expired && !wdt_q};
   assign irq_clr = wr_stat ? (wdata_q[IW-1:0] & {IW{wstrb_q[0]}}) : '0;
   assign next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
   assign irq = |(irq_stat & irq_mask);

   // status and mask
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq_stat <= '0;
         irq_mask <= mpc_pkg::IRQ_MASK_RESET;
      end
      else
      begin
         irq_stat <= next_irq_stat;
         if (wr_mask)
            irq_mask <= mask_merged[IW-1:0];
      end
   end

   //------------------------------------------------------------
   // read channel
   //------------------------------------------------------------
   // RULE6: config bits show real pin levels
   assign cfg_view = {18'h00000, cfg[CW-1:mpc_pkg::CFG_DSC_LSB],
                      general_io_two_i, general_io_one_i};
   assign pins_view = {22'h000000, wdt_expired, cell_count_sel,
                       monitor_mode, stack_top_strap, dev_address};
   assign temp_view = {4'h0, temp_two, 4'h0, temp_one};
   assign rd_word = (s_axi_araddr == mpc_pkg::ADDR_CFG) ? cfg_view :
      (s_axi_araddr == mpc_pkg::ADDR_PINS) ? pins_view :
      (s_axi_araddr == mpc_pkg::ADDR_TEMP) ? temp_view :
      (s_axi_araddr == mpc_pkg::ADDR_IRQ_STAT) ? 32'(irq_stat) :
      (s_axi_araddr == mpc_pkg::ADDR_IRQ_MASK) ? 32'(irq_mask) :
      32'h00000000;
   assign s_axi_arready = !s_axi_rvalid;

   // read data and response
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= mpc_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= mapped(s_axi_araddr) ? mpc_pkg::RESP_OKAY :
            mpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   // checks on the core clock, off during reset
   default clocking cb_core @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   sequence seq_cfg_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == mpc_pkg::ADDR_CFG;
   endsequence
   sequence seq_fire;
      !wdt_q && wdt_expired;
   endsequence

   AST_WDT_PIN: assert property (seq_fire ##0 !monitor_mode |-> // RULE2
      watchdog_fault_out_n_oe)
      else $error("watchdog pin not pulled on expiry");
   AST_CFG_DEFAULT: assert property (wdt_expired |=> // RULE2
      cfg == mpc_pkg::CFG_RESET && discharge_en == '0)
      else $error("configuration not defaulted by watchdog");
   AST_WDT_OD: assert property (watchdog_fault_out_n_o == 1'b0 && // RULE3
      general_io_one_o == 1'b0 && general_io_two_o == 1'b0)
      else $error("open-drain pin driven high");
   AST_GPIO_PULL: assert property (wr_cfg && !wdt_expired && // RULE4
      monitor_mode_in_n && wstrb_q[0] && !wdata_q[0] |=> general_io_one_oe)
      else $error("general pin not pulled after zero write");
   AST_GPIO_REL: assert property (cfg[mpc_pkg::CFG_GENERAL_IO_TWO_BIT] |-> // RULE5
      !general_io_two_oe)
      else $error("general pin driven while released");
   AST_GPIO_READ: assert property (seq_cfg_read |=> // RULE6
      s_axi_rdata[1:0] == {$past(general_io_two_i), $past(general_io_one_i)})
      else $error("config read did not return pin levels");
   AST_MON_INPUTS: assert property (!monitor_mode_in_n |-> // RULE8
      !watchdog_fault_out_n_oe && !general_io_one_oe && !general_io_two_oe)
      else $error("pin driven in monitor mode");
   AST_ADDR: assert property (rst_b |=> dev_address == $past( // RULE9
      {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}))
      else $error("address straps not captured");
   AST_TOS: assert property (poll_mode && !chip_select_in_n |-> // RULE10
      serial_data_out_oe == (stack_top_strap && !poll_toggle))
      else $error("polling output wrong for strap");
   AST_SDO_OD: assert property (serial_data_out_o == 1'b0 && // RULE11
      !(chip_select_in_n && serial_data_out_oe))
      else $error("serial data out driven high");
   AST_DISCH: assert property (!wr_cfg && !wdt_expired |=> // RULE13
      $stable(discharge_en))
      else $error("discharge switches changed on their own");
   AST_TEMP: assert property (temp_conv_done |=> // RULE15
      temp_one == $past(temp_sense_in_one) && irq_stat[mpc_pkg::IRQ_TEMP_DONE])
      else $error("temperature result not stored");
endmodule : mpc_pin_ctrl
`default_nettype wire

/* verification/mpc_pin_env.sv */
// Purpose: board around the pin control block: pull-ups and external pins
// Assumes: every open-drain line has a pull-up to the regulator output
// Notes: ext_low[0..3] pull gpio one, gpio two, watchdog and serial out low
`timescale 1ns/1ps
`default_nettype none
module mpc_pin_env
(
   input wire logic gpio_one_oe,
   input wire logic gpio_two_oe,
   input wire logic wdt_oe,
   input wire logic sdo_oe,
   input wire logic [3:0] ext_low,
   output logic gpio_one_lvl,
   output logic gpio_two_lvl,
   output logic wdt_lvl,
   output logic sdo_lvl
);
   // ------------------------------------------------
   // wired-and lines with pull-ups
   // ------------------------------------------------
   // external pull-up
   // wired levels: any enabled pull-down wins over the resistor
   assign gpio_one_lvl = !(gpio_one_oe | ext_low[0]);
   assign gpio_two_lvl = !(gpio_two_oe | ext_low[1]);
   assign wdt_lvl = !(wdt_oe | ext_low[2]);
   assign sdo_lvl = !(sdo_oe | ext_low[3]); // idle high when released
endmodule : mpc_pin_env
`default_nettype wire

/* verification/mpc_pin_ctrl_test.sv */
// Purpose: self-checking bench for the pin control block
// Assumes: short watchdog count, pins resolved by the board model
// Notes: register access through a small axi4-lite master
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module mpc_pin_ctrl_test;
   localparam int unsigned WDT_N = 20;
   logic core_clk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, sck_run = 1'b1;
   logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, serial_clock_in = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic [3:0] s_axi_wstrb = 4'hF, rx_addr = 4'h0, ext_low = 4'h0;
   logic chip_select_in_n = 1'b1, monitor_mode_in_n = 1'b1;
   logic addr_strap_bit0 = 1'b0, addr_strap_bit1 = 1'b1;
   logic addr_strap_bit2 = 1'b0, addr_strap_bit3 = 1'b1;
   logic stack_top_strap = 1'b1, sdo_tx_bit = 1'b1, poll_mode = 1'b0;
   logic poll_toggle = 1'b0, temp_conv_done = 1'b0, sdo_lvl;
   logic [11:0] temp_sense_in_one = 12'h000, temp_sense_in_two = 12'h000;
   logic [1:0] resp, s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq, addr_match, monitor_mode;
   logic [31:0] s_axi_rdata;
   logic watchdog_fault_out_n_i, watchdog_fault_out_n_o;
   logic watchdog_fault_out_n_oe, general_io_one_i, general_io_one_o;
   logic general_io_one_oe, general_io_two_i, general_io_two_o;
   logic general_io_two_oe, serial_data_out_o, serial_data_out_oe;
   logic [3:0] dev_address;
   logic [11:0] discharge_en;
   logic [2:0] cell_count_sel;
   int err_count = 0;
   int n_compared = 0;

   mpc_pin_ctrl #(.WDT_CYCLES(WDT_N)) u_dut (.*);
   mpc_pin_env u_env (.gpio_one_oe(general_io_one_oe),
      .gpio_two_oe(general_io_two_oe), .wdt_oe(watchdog_fault_out_n_oe),
      .sdo_oe(serial_data_out_oe), .ext_low(ext_low),
      .gpio_one_lvl(general_io_one_i), .gpio_two_lvl(general_io_two_i),
      .wdt_lvl(watchdog_fault_out_n_i), .sdo_lvl(sdo_lvl));

   // clock and serial clock activity
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (sck_run) serial_clock_in <= ~serial_clock_in;

   // ------------------------------------------------
   // bus master tasks
   // ------------------------------------------------
   // write: handshakes sampled at the rising edge that moves them
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      begin
         tb = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         repeat (50) if (!tb)
         begin
            @(posedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            resp = s_axi_bresp;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
         end
         if (!tb) err_count++;
      end
   endtask : wr

   // read: result left in rd and resp
   task automatic rdr(input logic [7:0] a);
      logic ta, tb;
      begin
         tb = 1'b0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         repeat (50) if (!tb)
         begin
            @(posedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tb = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            if (ta) s_axi_arvalid <= 1'b0;
         end
         if (!tb) err_count++;
      end
   endtask : rdr

   task automatic complete_run;
      if (err_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run

   // hang guard
   initial
   begin
      repeat (5000) @(posedge core_clk);
      err_count++;
      complete_run();
   end

   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      rdr(mpc_pkg::ADDR_CFG);
      `CHK(rd, 32'h0000_0003)
      rdr(mpc_pkg::ADDR_IRQ_MASK);
      `CHK(rd, 32'h0)
      // gpio one pulled low, gpio two released, all discharge on
      wr(mpc_pkg::ADDR_CFG, 32'h0000_3FFE);
      `CHK({general_io_two_oe, general_io_one_oe}, 2'b01)
      `CHK({general_io_two_o, general_io_one_o}, 2'b00)
      `CHK(discharge_en, 12'hFFF)
      rdr(mpc_pkg::ADDR_CFG);
      `CHK(rd, 32'h0000_3FFE)
      ext_low <= 4'h2;
      rdr(mpc_pkg::ADDR_CFG);
      `CHK(rd, 32'h0000_3FFC)
      ext_low <= 4'h0;
      // straps and address filter
      rdr(mpc_pkg::ADDR_PINS);
      `CHK(rd[5:0], 6'h1A)
      `CHK(dev_address, 4'hA)
      rx_addr <= 4'hA;
      @(negedge core_clk);
      `CHK(addr_match, 1'b1)
      @(posedge core_clk);
      rx_addr <= 4'h5;
      @(negedge core_clk);
      `CHK(addr_match, 1'b0)
      // serial out enable over every select, poll and strap case
      for (int i = 0; i < 32; i++)
      begin
         @(posedge core_clk);
         {chip_select_in_n, poll_mode, sdo_tx_bit} <= i[4:2];
         {stack_top_strap, poll_toggle} <= i[1:0];
         @(negedge core_clk);
         `CHK(serial_data_out_oe, !i[4] & (i[3] ? i[1] & !i[0] : !i[2]))
         `CHK(serial_data_out_o, 1'b0)
         `CHK(sdo_lvl, !serial_data_out_oe)
      end
      @(posedge core_clk);
      stack_top_strap <= 1'b1;
      chip_select_in_n <= 1'b1;
      // temperature capture
      temp_sense_in_one <= 12'h5A3;
      temp_sense_in_two <= 12'h0C7;
      temp_conv_done <= 1'b1;
      @(posedge core_clk);
      temp_conv_done <= 1'b0;
      rdr(mpc_pkg::ADDR_TEMP);
      `CHK(rd, 32'h00C7_05A3)
      wr(mpc_pkg::ADDR_IRQ_STAT, 32'h2);
      // watchdog expiry with interrupt
      wr(mpc_pkg::ADDR_IRQ_MASK, 32'h7);
      `CHK(irq, 1'b0)
      sck_run <= 1'b0;
      repeat (WDT_N - 3) @(posedge core_clk);
      `CHK(watchdog_fault_out_n_oe, 1'b0)
      repeat (8) @(posedge core_clk);
      `CHK(watchdog_fault_out_n_oe, 1'b1)
      `CHK({watchdog_fault_out_n_o, watchdog_fault_out_n_i}, 2'b00)
      `CHK(discharge_en, 12'h000)
      `CHK({general_io_two_oe, general_io_one_oe}, 2'b00)
      `CHK(irq, 1'b1)
      wr(mpc_pkg::ADDR_CFG, 32'h0000_3FFC);
      `CHK(discharge_en, 12'h000)
      rdr(mpc_pkg::ADDR_PINS);
      `CHK(rd[9], 1'b1)
      rdr(mpc_pkg::ADDR_IRQ_STAT);
      `CHK(rd[0], 1'b1)
      wr(mpc_pkg::ADDR_IRQ_STAT, 32'h1);
      `CHK(irq, 1'b0)
      sck_run <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK(watchdog_fault_out_n_oe, 1'b0)
      `CHK(irq, 1'b1)
      wr(mpc_pkg::ADDR_IRQ_STAT, 32'h7);
      `CHK(irq, 1'b0)
      // monitor mode turns pins into cell-count inputs
      wr(mpc_pkg::ADDR_CFG, 32'h0);
      monitor_mode_in_n <= 1'b0;
      ext_low <= 4'h5;
      repeat (3) @(posedge core_clk);
      `CHK(monitor_mode, 1'b1)
      `CHK({general_io_two_oe, general_io_one_oe}, 2'b00)
      `CHK(cell_count_sel, 3'b010)
      ext_low <= 4'h2;
      repeat (3) @(posedge core_clk);
      `CHK(cell_count_sel, 3'b101)
      rdr(mpc_pkg::ADDR_PINS);
      `CHK(rd[8:5], 4'hB)
      monitor_mode_in_n <= 1'b1;
      ext_low <= 4'h0;
      // unmapped and read-only places
      rdr(8'h14);
      `CHK({resp, rd}, {mpc_pkg::RESP_SLVERR, 32'h0})
      wr(mpc_pkg::ADDR_PINS, 32'hFFFF_FFFF);
      `CHK(resp, mpc_pkg::RESP_OKAY)
      complete_run();
   end
endmodule : mpc_pin_ctrl_test
`default_nettype wire
